// ### logic/tape_glue_pkg.sv
// Constants and carrier types for the tape/disk expansion card glue
package tape_glue_pkg;

    // Host address decode (byte-wide, word-aligned selects)
    localparam logic [1:0] SEL_STATUS  = 2'h0;
    localparam logic [1:0] SEL_LATCH   = 2'h1;
    localparam logic [1:0] SEL_PAGE    = 2'h2;
    localparam logic [1:0] SEL_ROM     = 2'h3;

    // Control latch field positions
    localparam int LATCH_RELEASE  = 7;
    localparam int LATCH_SPINDLE  = 6;
    localparam int LATCH_FINAL    = 5;
    localparam int LATCH_CTRL_RST = 4;
    localparam int LATCH_GATE     = 3;
    localparam int LATCH_HOLD     = 2;
    localparam int LATCH_RATE     = 1;
    localparam int LATCH_EDGE     = 0;

    // Status field positions
    localparam int STAT_XFER   = 2;
    localparam int STAT_BUSY   = 1;
    localparam int STAT_RESULT = 0;

    // ROM paging: 256 kbyte in 2 kbyte pages
    localparam int PAGE_OFFS_W = 11;
    localparam int PAGE_SEL_W  = 7;
    localparam int ROM_ADDR_W  = PAGE_OFFS_W + PAGE_SEL_W;

    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] PAGE_RESET  = 8'h00;

    typedef struct packed {
        logic release_media;
        logic spindle_run;
        logic transfer_final;
        logic disk_ctrl_reset_bit;
        logic request_gate;
        logic index_hold_arm;
        logic rate_select;
        logic edge_watch_allow;
    } latch_t;

    // Host bus request
    typedef struct packed {
        logic                  sel;
        logic                  wr;
        logic                  rd;
        logic [1:0]            reg_sel;
        logic [PAGE_OFFS_W-1:0] offs;
    } host_req_t;

endpackage

// ### logic/tape_disk_podule_glue.sv
// Glue logic between the byte-wide host expansion bus and the disk controller
// ---------------------------------------------------------------------------
// Notes on behaviour
// - Host data path is eight bits; each access moves one byte.
// - Request lines are driven low, enabled only while asserted.
// - Normal request from toggle flag or controller; fast from transfer request.
// - Both requests suppressed while request gate bit is low.
// - 256 kbyte ROM seen through 2 kbyte window chosen by page register.
// - Latch bits 7..4: media release, spindle run, transfer final, controller reset.
// - Latch bits 3..0: request gate, index hold, rate select, edge allow.
// - Latch outputs active high, cleared by bus reset except controller reset, which bus reset sets.
// - Controller reset is bus reset or latch reset bit.
// - Status bits: 2 transfer request, 1 busy level, 0 result request.
// - Index hold low keeps passed index high so no pulses reach controller.
// - With hold set, next index trailing edge blocks pulses until cleared.
// - Edge allow set: toggle flag rises on each busy line edge.
// - Reading the status port clears the toggle flag request.
// - Ready or media swapped line routed through selectable mux to error input.
// ---------------------------------------------------------------------------
`timescale 1ns/10ps
module tape_disk_podule_glue
    import tape_glue_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    // Host bus
    input  wire host_req_t             host_req_i,
    input  wire logic [7:0]            host_data_i,
    output logic [7:0]                 host_data_o,
    output logic                       host_data_oe_o,
    // Request lines, open drain, active low on the wire
    output logic                       fast_req_o,
    output logic                       fast_req_oe_o,
    output logic                       norm_req_o,
    output logic                       norm_req_oe_o,
    // ROM
    output logic [ROM_ADDR_W-1:0]      rom_addr_o,
    input  wire logic [7:0]            rom_data_i,
    // Disk controller
    input  wire logic                  transfer_request_line_i,
    input  wire logic                  ctrl_result_req_i,
    output logic                       ctrl_reset_o,
    output logic                       transfer_final_o,
    output logic                       passed_index_pulse_o,
    output logic                       drive_error_o,
    // Drive cable
    input  wire logic                  index_i,
    input  wire logic                  track_zero_line_i,
    input  wire logic                  ready_or_media_swapped_i,
    input  wire logic                  error_mux_sel_i,
    input  wire logic                  drive_fault_i,
    output logic                       media_release_o,
    output logic                       spindle_run_o,
    output logic                       rate_select_o
);

    latch_t                 latch_q;
    latch_t                 latch_d;
    logic [PAGE_SEL_W-1:0]  page_q;
    logic [PAGE_SEL_W-1:0]  page_d;
    logic                   busy_q;
    logic                   index_q;
    logic                   toggle_q;
    logic                   toggle_d;
    logic                   blocked_q;
    logic                   blocked_d;
    logic                   latch_wr;
    logic                   page_wr;
    logic                   stat_rd;
    logic                   busy_edge;
    logic                   index_fall;
    logic                   hold_fall;
    logic                   fast_act;
    logic                   norm_act;
    logic [7:0]             status_byte;
    logic                   error_src;

    // ---------------------------------------------------------------
    // Host access decode
    // ---------------------------------------------------------------
    assign latch_wr = host_req_i.sel && host_req_i.wr && (host_req_i.reg_sel == SEL_LATCH);
    assign page_wr  = host_req_i.sel && host_req_i.wr && (host_req_i.reg_sel == SEL_PAGE);
    assign stat_rd  = host_req_i.sel && host_req_i.rd && (host_req_i.reg_sel == SEL_STATUS);

    // ---------------------------------------------------------------
    // Control latch
    // ---------------------------------------------------------------
    always_comb begin
        latch_d = latch_q;
        if (latch_wr) begin
            latch_d = latch_t'(host_data_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            latch_q <= latch_t'(LATCH_RESET);
        end else begin
            latch_q <= latch_d;
        end
    end

    // ---------------------------------------------------------------
    // Page register
    // ---------------------------------------------------------------
    always_comb begin
        page_d = page_q;
        if (page_wr) begin
            page_d = host_data_i[PAGE_SEL_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            page_q <= PAGE_RESET[PAGE_SEL_W-1:0];
        end else begin
            page_q <= page_d;
        end
    end

    // ---------------------------------------------------------------
    // Status word
    // ---------------------------------------------------------------
    always_comb begin
        status_byte              = 8'h00;
        status_byte[STAT_XFER]   = transfer_request_line_i;
        status_byte[STAT_BUSY]   = track_zero_line_i;
        status_byte[STAT_RESULT] = ctrl_result_req_i;
    end

    // ---------------------------------------------------------------
    // Read data enable
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            host_data_oe_o <= 1'b0;
        end else begin
            host_data_oe_o <= host_req_i.sel && host_req_i.rd;
        end
    end

    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            host_data_o <= 8'h00;
        end else if (host_req_i.reg_sel == SEL_STATUS) begin
            host_data_o <= status_byte;
        end else begin
            host_data_o <= rom_data_i;
        end
    end

    // ---------------------------------------------------------------
    // ROM address
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rom_addr_o <= '0;
        end else begin
            rom_addr_o <= {page_q, host_req_i.offs};
        end
    end

    // ---------------------------------------------------------------
    // Busy line edge detect
    // ---------------------------------------------------------------
    assign busy_edge = busy_q != track_zero_line_i;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= track_zero_line_i;
        end
    end

    // ---------------------------------------------------------------
    // Toggle flag
    // ---------------------------------------------------------------
    always_comb begin
        toggle_d = toggle_q;
        if (latch_q.edge_watch_allow && busy_edge) begin
            toggle_d = 1'b1;
        end else if (stat_rd) begin
            toggle_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            toggle_q <= 1'b0;
        end else begin
            toggle_q <= toggle_d;
        end
    end

    // ---------------------------------------------------------------
    // Index edge detect
    // ---------------------------------------------------------------
    assign index_fall = index_q && !index_i;
    assign hold_fall  = latch_q.index_hold_arm && index_fall;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            index_q <= 1'b0;
        end else begin
            index_q <= index_i;
        end
    end

    // ---------------------------------------------------------------
    // Index blocking
    // ---------------------------------------------------------------
    always_comb begin
        blocked_d = blocked_q;
        if (!latch_q.index_hold_arm) begin
            blocked_d = 1'b0;
        end else if (hold_fall) begin
            blocked_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            blocked_q <= 1'b0;
        end else begin
            blocked_q <= blocked_d;
        end
    end

    // ---------------------------------------------------------------
    // Request sources
    // ---------------------------------------------------------------
    assign fast_act = latch_q.request_gate && transfer_request_line_i;
    assign norm_act = latch_q.request_gate && (toggle_q || ctrl_result_req_i);

    // ---------------------------------------------------------------
    // Fast request line
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fast_req_o    <= 1'b0;
            fast_req_oe_o <= 1'b0;
        end else begin
            fast_req_o    <= 1'b0;
            fast_req_oe_o <= fast_act;
        end
    end

    // ---------------------------------------------------------------
    // Normal request line
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            norm_req_o    <= 1'b0;
            norm_req_oe_o <= 1'b0;
        end else begin
            norm_req_o    <= 1'b0;
            norm_req_oe_o <= norm_act;
        end
    end

    // ---------------------------------------------------------------
    // Controller reset
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_reset_o <= 1'b1;
        end else begin
            ctrl_reset_o <= latch_q.disk_ctrl_reset_bit;
        end
    end

    // ---------------------------------------------------------------
    // Transfer final
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            transfer_final_o <= 1'b0;
        end else begin
            transfer_final_o <= latch_q.transfer_final;
        end
    end

    // ---------------------------------------------------------------
    // Passed index level
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            passed_index_pulse_o <= 1'b1;
        end else begin
            passed_index_pulse_o <= !(blocked_q || hold_fall);
        end
    end

    // ---------------------------------------------------------------
    // Drive error source
    // ---------------------------------------------------------------
    assign error_src = error_mux_sel_i ? ready_or_media_swapped_i : drive_fault_i;

    // ---------------------------------------------------------------
    // Drive error output
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            drive_error_o <= 1'b0;
        end else begin
            drive_error_o <= error_src;
        end
    end

    // ---------------------------------------------------------------
    // Media release
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            media_release_o <= 1'b0;
        end else begin
            media_release_o <= latch_q.release_media;
        end
    end

    // ---------------------------------------------------------------
    // Spindle run
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            spindle_run_o <= 1'b0;
        end else begin
            spindle_run_o <= latch_q.spindle_run;
        end
    end

    // ---------------------------------------------------------------
    // Recording rate select
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rate_select_o <= 1'b0;
        end else begin
            rate_select_o <= latch_q.rate_select;
        end
    end

endmodule

// ### tb/far_side_model.sv
// Firmware ROM and spinning drive model at the card's far side
`timescale 1ns/10ps
module far_side_model
    import tape_glue_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  spin_i,
    input  wire logic [ROM_ADDR_W-1:0] addr_i,
    output logic [7:0]                 data_o,
    output logic                       index_o
);
    logic [4:0] rev_q;
    // Byte depends on page and offset
    assign data_o = addr_i[7:0] ^ {1'b0, addr_i[17:11]};
    // One index pulse a revolution while spinning
    always_ff @(posedge clk_i) begin
        rev_q <= spin_i ? rev_q + 5'h01 : 5'h00;
    end
    assign index_o = spin_i && (rev_q < 5'h04);
endmodule

// ### tb/glue_asserts.sv
// Port checker for the card glue
`timescale 1ns/10ps
module glue_asserts
    import tape_glue_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    // Host bus
    input  wire host_req_t             host_req_i,
    input  wire logic [7:0]            host_data_i,
    input  wire logic [7:0]            host_data_o,
    input  wire logic                  host_data_oe_o,
    // Request lines
    input  wire logic                  fast_req_o,
    input  wire logic                  fast_req_oe_o,
    input  wire logic                  norm_req_o,
    // ROM
    input  wire logic [ROM_ADDR_W-1:0] rom_addr_o,
    // Disk controller and drive cable
    input  wire logic                  transfer_request_line_i,
    input  wire logic                  ctrl_result_req_i,
    input  wire logic                  ctrl_reset_o,
    input  wire logic                  transfer_final_o,
    input  wire logic                  passed_index_pulse_o,
    input  wire logic                  drive_error_o,
    input  wire logic                  track_zero_line_i,
    input  wire logic                  ready_or_media_swapped_i,
    input  wire logic                  error_mux_sel_i,
    input  wire logic                  drive_fault_i,
    input  wire logic                  media_release_o,
    input  wire logic                  spindle_run_o,
    input  wire logic                  rate_select_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    chk_req_drive_low: assert property (!fast_req_o && !norm_req_o)
        else $error("request line driven high");
    chk_fast_cause: assert property (fast_req_oe_o |-> $past(transfer_request_line_i))
        else $error("fast request without cause");
    chk_read_enable: assert property (
        host_data_oe_o == $past(host_req_i.sel && host_req_i.rd))
        else $error("data enable wrong");
    chk_status_bits: assert property (host_req_i.sel && host_req_i.rd &&
        host_req_i.reg_sel == SEL_STATUS |=> host_data_o[STAT_BUSY] == $past(track_zero_line_i)
        && host_data_o[STAT_XFER] == $past(transfer_request_line_i)
        && host_data_o[STAT_RESULT] == $past(ctrl_result_req_i)) else $error("status bits");
    chk_latch_capture: assert property (host_req_i.sel && host_req_i.wr &&
        host_req_i.reg_sel == SEL_LATCH |-> ##2 spindle_run_o == $past(host_data_i[6], 2))
        else $error("latch not captured");
    chk_page_window: assert property (host_req_i.sel && host_req_i.rd &&
        host_req_i.reg_sel == SEL_ROM |=> rom_addr_o[10:0] == $past(host_req_i.offs))
        else $error("rom offset wrong");
    chk_error_route: assert property (!$past(reset_i) |-> drive_error_o ==
        $past(error_mux_sel_i ? ready_or_media_swapped_i : drive_fault_i)) else $error("mux");
    chk_reset_state: assert property (disable iff (1'b0) reset_i |=> ctrl_reset_o &&
        passed_index_pulse_o && !media_release_o && !spindle_run_o && !transfer_final_o
        && !rate_select_o) else $error("reset state wrong");
endmodule
bind tape_disk_podule_glue glue_asserts u_chk(.clk_i, .reset_i, .fast_req_o, .norm_req_o,
    .host_data_oe_o, .spindle_run_o, .fast_req_oe_o, .transfer_request_line_i,
    .track_zero_line_i, .drive_fault_i, .error_mux_sel_i, .ready_or_media_swapped_i,
    .drive_error_o, .ctrl_reset_o, .media_release_o, .transfer_final_o, .rate_select_o,
    .passed_index_pulse_o, .host_req_i, .host_data_i, .host_data_o, .rom_addr_o,
    .ctrl_result_req_i);

// ### tb/tb_tape_disk_podule_glue.sv
// Testbench for the card glue
`timescale 1ns/10ps
module tb_tape_disk_podule_glue;
    import tape_glue_pkg::*;
    logic clk_i = 0, reset_i = 1, transfer_request_line_i = 0, ctrl_result_req_i = 0;
    logic track_zero_line_i = 0, error_mux_sel_i = 0, ready_or_media_swapped_i = 1;
    logic drive_fault_i = 0, index_i, host_data_oe_o, fast_req_o, fast_req_oe_o, norm_req_o;
    logic norm_req_oe_o, ctrl_reset_o, transfer_final_o, passed_index_pulse_o, drive_error_o;
    logic media_release_o, spindle_run_o, rate_select_o;
    host_req_t host_req_i = '0;
    logic [7:0] host_data_i = 8'h00, host_data_o, rom_data_i, d;
    logic [ROM_ADDR_W-1:0] rom_addr_o;
    int num_errors = 0, checked = 0, n;
    always #4 clk_i = ~clk_i;
    tape_disk_podule_glue dut(.clk_i, .reset_i, .host_req_i, .host_data_i, .host_data_o,
        .host_data_oe_o, .fast_req_o, .fast_req_oe_o, .norm_req_o, .norm_req_oe_o,
        .rom_addr_o, .rom_data_i, .transfer_request_line_i, .ctrl_result_req_i, .ctrl_reset_o,
        .transfer_final_o, .passed_index_pulse_o, .drive_error_o, .index_i,
        .track_zero_line_i, .ready_or_media_swapped_i, .error_mux_sel_i, .drive_fault_i,
        .media_release_o, .spindle_run_o, .rate_select_o);
    far_side_model far(.clk_i, .spin_i(spindle_run_o), .addr_i(rom_addr_o),
        .data_o(rom_data_i), .index_o(index_i));
    task automatic chk(input logic [17:0] g, input logic [17:0] e);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [1:0] s, input logic [7:0] v);
        @(negedge clk_i);
        host_req_i = '{1'b1, 1'b1, 1'b0, s, 11'h000};
        host_data_i = v;
        @(negedge clk_i);
        host_req_i = '0;
        repeat (3) @(negedge clk_i);
    endtask
    task automatic rd(input logic [1:0] s, input logic [10:0] o);
        @(negedge clk_i);
        host_req_i = '{1'b1, 1'b0, 1'b1, s, o};
        repeat (2) @(posedge clk_i);
        #1 d = host_data_o;
        @(negedge clk_i);
        host_req_i = '0;
    endtask
    task automatic falls;
        logic p;
        n = 0;
        p = passed_index_pulse_o;
        repeat (80) begin
            @(negedge clk_i);
            if (p && !passed_index_pulse_o) n++;
            p = passed_index_pulse_o;
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #50000 num_errors++;
        summarize();
    end
    initial begin
        repeat (10) @(negedge clk_i);
        reset_i = 0;
        chk({ctrl_reset_o, passed_index_pulse_o, spindle_run_o}, 18'h6);
        wr(SEL_LATCH, 8'hFF);
        chk({media_release_o, spindle_run_o, transfer_final_o, ctrl_reset_o}, 18'hF);
        chk(rate_select_o, 18'h1);
        wr(SEL_LATCH, 8'h00);
        chk({media_release_o, ctrl_reset_o, rate_select_o}, 18'h0);
        $display("latch test done");
        transfer_request_line_i = 1;
        ctrl_result_req_i = 1;
        repeat (3) @(negedge clk_i);
        chk({fast_req_oe_o, norm_req_oe_o}, 18'h0);
        ctrl_result_req_i = 0;
        wr(SEL_LATCH, 8'h08);
        chk({fast_req_oe_o, fast_req_o}, 18'h2);
        rd(SEL_STATUS, 11'h000);
        chk(d[2:0], 18'h4);
        transfer_request_line_i = 0;
        ctrl_result_req_i = 1;
        rd(SEL_STATUS, 11'h000);
        chk({d[2:0], norm_req_oe_o, norm_req_o}, 18'h6);
        ctrl_result_req_i = 0;
        $display("gate test done");
        wr(SEL_LATCH, 8'h09);
        for (int i = 0; i < 2; i++) begin
            track_zero_line_i = ~track_zero_line_i;
            repeat (3) @(negedge clk_i);
            chk(norm_req_oe_o, 18'h1);
            rd(SEL_STATUS, 11'h000);
            chk(d[2:0], {16'h0, ~track_zero_line_i ^ 1'b1, 1'b0});
            repeat (2) @(negedge clk_i);
            chk(norm_req_oe_o, 18'h0);
        end
        wr(SEL_LATCH, 8'h08);
        track_zero_line_i = 1;
        repeat (3) @(negedge clk_i);
        chk(norm_req_oe_o, 18'h0);
        $display("edge test done");
        wr(SEL_LATCH, 8'h40);
        falls();
        chk({n == 0, passed_index_pulse_o}, 18'h3);
        wr(SEL_LATCH, 8'h44);
        falls();
        chk({n < 2, passed_index_pulse_o}, 18'h2);
        falls();
        chk({n == 0, passed_index_pulse_o}, 18'h2);
        wr(SEL_LATCH, 8'h40);
        falls();
        chk({n == 0, passed_index_pulse_o}, 18'h3);
        $display("index test done");
        wr(SEL_PAGE, 8'h85);
        rd(SEL_ROM, 11'h5A3);
        chk(rom_addr_o, {7'h05, 11'h5A3});
        chk(d, 18'h0A6);
        for (int m = 0; m < 2; m++) begin
            error_mux_sel_i = m[0];
            repeat (2) @(negedge clk_i);
            chk(drive_error_o, m);
        end
        $display("rom and mux test done");
        wr(SEL_LATCH, 8'hFF);
        reset_i = 1;
        repeat (2) @(negedge clk_i);
        chk({media_release_o, spindle_run_o, rate_select_o, ctrl_reset_o}, 18'h1);
        chk(passed_index_pulse_o, 18'h1);
        reset_i = 0;
        repeat (2) @(negedge clk_i);
        chk({ctrl_reset_o, transfer_final_o, spindle_run_o}, 18'h0);
        $display("reset test done");
        summarize();
    end
endmodule
